//--- common/cmbi_map.svh
// Constants for the processor bus interface block.
// Assumes inclusion by the package, the top module and the bench top only.
`ifndef CMBI_MAP_SVH
`define CMBI_MAP_SVH
`define CMBI_ADDR_W        15
`define CMBI_DATA_W        16
`define CMBI_LVL_W         4
`define CMBI_RESET_VEC     15'h0000
`define CMBI_LOAD_VEC      15'h7ffe
`define CMBI_INT_VEC_BASE  15'h0000
`define CMBI_RESET_PC      15'h0000
`define CMBI_SER_LD        4'h1
`define CMBI_SER_SB1       4'h2
`define CMBI_SER_SB0       4'h3
// 3.0 MHz bus cycle derived from a 250 MHz clock, at least one cycle
`define CMBI_CLK_MHZ       250
`define CMBI_BUS_MHZ_X10   30
`define CMBI_PHASE_CYC \
  ((`CMBI_CLK_MHZ*10+4*`CMBI_BUS_MHZ_X10-1)/(4*`CMBI_BUS_MHZ_X10))
`endif

//--- common/cmbi_pkg.sv
// Types for the processor bus interface block.
// Assumes cmbi_map.svh is on the include path.
`include "cmbi_map.svh"
package cmbi_pkg;
  typedef enum logic [2:0] {
    CMBI_IDLE  = 3'b000,
    CMBI_ADDR  = 3'b001,
    CMBI_XFER  = 3'b011,
    CMBI_DONE  = 3'b010,
    CMBI_HOLD  = 3'b110,
    CMBI_SER   = 3'b111,
    CMBI_RST   = 3'b101
  } cmbi_state_t;

  typedef struct packed {
    logic                    valid;
    logic                    write;
    logic                    fetch;
    logic [`CMBI_ADDR_W-1:0] addr;
    logic [`CMBI_DATA_W-1:0] wdata;
  } cmbi_req_t;

  typedef struct packed {
    logic                    mem_cycle_enable;
    logic                    data_in_strobe;
    logic                    write_enable;
    logic                    wait_flag;
    logic                    bus_grant_ack;
    logic                    instr_fetch_flag;
    logic                    addr_oe;
    logic                    data_oe;
    logic [`CMBI_ADDR_W-1:0] addr;
    logic [`CMBI_DATA_W-1:0] data;
  } cmbi_bus_t;

  typedef struct packed {
    logic                    start;
    logic [`CMBI_LVL_W-1:0]  kind;
    logic [`CMBI_ADDR_W-1:0] addr;
    logic                    bit_val;
  } cmbi_ser_req_t;

  typedef struct packed {
    logic                    serial_out_bit;
    logic                    serial_strobe;
    logic [`CMBI_ADDR_W-1:0] addr;
  } cmbi_ser_t;

  typedef struct packed {
    cmbi_state_t             st;
    logic [7:0]              phase;
    logic [1:0]              tick;
    logic                    released;
    logic                    pend_rst;
    logic                    pend_nmi;
    logic                    load_prev;
    logic                    status_clr;
    logic                    req_done;
    logic                    ser_done;
    logic [`CMBI_DATA_W-1:0] rdata;
    logic                    ser_in;
    logic [`CMBI_LVL_W-1:0]  irq_level;
    logic                    irq_seen;
    logic [`CMBI_ADDR_W-1:0] vec;
    logic                    vec_pulse;
    cmbi_req_t               cur;
    cmbi_ser_req_t           ser;
    cmbi_bus_t               bus;
    cmbi_ser_t               sio;
  } cmbi_state_rec_t;
endpackage : cmbi_pkg

//--- rtl/cmbi_top.sv
// Bus interface unit of a 16-bit processor: memory cycles, hold, serial
// unit strobes, reset and interrupt entry. Assumes the core issues one
// request at a time and holds it until its done pulse.
`timescale 1ns/1ps
`include "cmbi_map.svh"

// Notes on behaviour
// - Wait output stays high while a cycle stalls for memory ready.
// - Load input rising forces non-maskable interrupt through fixed vector.
// - Hold-acknowledge high while sitting in hold state.
// - In reset stay idle; on release run interrupt entry, clear status, start.
// - Instruction-fetch flag high during fetch bus cycles.
// - Data-in strobe lets memory drive; memory drives only while strobe high.
// - Serial output bit presented during load, set-one, set-zero operations.
// - Serial strobe pulses when outside logic samples bit or decodes address.
// - Write-enable asserted when data is to be written to memory.
// - Memory-enable high whenever the address bus carries a memory address.
// - Read: address out, data-in and memory-enable high, write-enable low.
// - During reads the data bus drivers are off.
// - Write: enable and write-enable high, data-in low, address and data held.
// - Tri-state 15-bit address bus and 16-bit bidirectional data bus.
// - Bus sequencing runs at no more than the 3.0 MHz maximum rate.
module cmbi_top #(
  parameter int PHASE_CYC = `CMBI_PHASE_CYC
) (
  input  wire logic                    clock,
  input  wire logic                    rstn,
  input  wire cmbi_pkg::cmbi_req_t     core_req,
  output logic                         core_done,
  output logic [`CMBI_DATA_W-1:0]      core_rdata,
  input  wire cmbi_pkg::cmbi_ser_req_t ser_req,
  output logic                         ser_done,
  output logic                         ser_in_val,
  output logic                         vec_take,
  output logic [`CMBI_ADDR_W-1:0]      vec_addr,
  output logic                         status_clear,
  output logic [`CMBI_LVL_W-1:0]       irq_level,
  output logic                         irq_pending,
  output cmbi_pkg::cmbi_bus_t          bus,
  output cmbi_pkg::cmbi_ser_t          sio,
  input  wire logic [`CMBI_DATA_W-1:0] data_i,
  input  wire logic                    ready,
  input  wire logic                    hold,
  input  wire logic                    load,
  input  wire logic                    reset_in,
  input  wire logic                    irq_in,
  input  wire logic                    irq_level_msb,
  input  wire logic                    irq_level_b1,
  input  wire logic                    irq_level_b2,
  input  wire logic                    irq_level_lsb,
  input  wire logic                    serial_in_bit
);
  import cmbi_pkg::*;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  localparam int NS = 9;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] pins;
  assign pins = {ready, hold, load, reset_in, irq_in, irq_level_msb,
                 irq_level_b1, irq_level_b2, irq_level_lsb};
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end
  logic s_rdy, s_hold, s_load, s_rst, s_irq;
  logic [`CMBI_LVL_W-1:0] s_lvl;
  assign s_rdy  = s2_q[8];
  assign s_hold = s2_q[7];
  assign s_load = s2_q[6];
  assign s_rst  = s2_q[5];
  assign s_irq  = s2_q[4];
  assign s_lvl  = s2_q[3:0];

  // Data bus is sampled every clock through two flops, whatever the strobe
  logic [`CMBI_DATA_W-1:0] d1_q, d2_q;
  logic                    sin1_q, sin2_q;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      d1_q   <= '0;
      d2_q   <= '0;
      sin1_q <= 1'b0;
      sin2_q <= 1'b0;
    end else begin
      d1_q   <= data_i;
      d2_q   <= d1_q;
      sin1_q <= serial_in_bit;
      sin2_q <= sin1_q;
    end
  end

  function automatic logic phase_end(input logic [7:0] ph, input int n);
    return ph == 8'(n - 1);
  endfunction : phase_end

  // ==========================================================
  // State
  // ==========================================================
  cmbi_state_rec_t r_q, r_d;

  always_comb begin
    r_d = r_q;
    r_d.req_done  = 1'b0;
    r_d.ser_done  = 1'b0;
    r_d.vec_pulse = 1'b0;
    r_d.status_clr = 1'b0;
    r_d.sio.serial_strobe = 1'b0;
    r_d.load_prev = s_load;
    r_d.irq_level = s_lvl;
    r_d.irq_seen  = s_irq;
    r_d.phase = phase_end(r_q.phase, PHASE_CYC) ? 8'h00 : r_q.phase + 8'h01;
    if (s_rst) begin
      r_d.st = CMBI_RST;
      r_d.pend_rst = 1'b1;
      r_d.bus = '0;
      r_d.phase = 8'h00;
    end else if (phase_end(r_q.phase, PHASE_CYC)) begin
      case (r_q.st)
        CMBI_RST: begin
          r_d.st = CMBI_IDLE;
        end
        CMBI_IDLE: begin
          r_d.bus.wait_flag = 1'b0;
          if (r_q.pend_rst) begin
            r_d.pend_rst   = 1'b0;
            r_d.status_clr = 1'b1;
            r_d.vec        = `CMBI_RESET_VEC;
            r_d.vec_pulse  = 1'b1;
            r_d.pend_nmi   = 1'b0;
          end else if (r_q.pend_nmi) begin
            r_d.pend_nmi  = 1'b0;
            r_d.vec       = `CMBI_LOAD_VEC;
            r_d.vec_pulse = 1'b1;
          end else if (s_hold) begin
            r_d.bus.addr_oe = 1'b0;
            r_d.bus.data_oe = 1'b0;
            r_d.st = CMBI_HOLD;
          end else if (ser_req.start) begin
            r_d.ser = ser_req;
            r_d.sio.addr = ser_req.addr;
            r_d.sio.serial_out_bit = ser_req.bit_val;
            r_d.st = CMBI_SER;
          end else if (core_req.valid) begin
            r_d.cur = core_req;
            r_d.bus.addr = core_req.addr;
            r_d.bus.addr_oe = 1'b1;
            r_d.bus.mem_cycle_enable = 1'b1;
            r_d.bus.instr_fetch_flag = core_req.fetch;
            r_d.bus.data_in_strobe = !core_req.write;
            r_d.bus.write_enable = 1'b0;
            r_d.bus.data = core_req.wdata;
            r_d.bus.data_oe = core_req.write;
            r_d.st = CMBI_ADDR;
          end
        end
        CMBI_ADDR: begin
          r_d.bus.write_enable = r_q.cur.write;
          r_d.st = CMBI_XFER;
        end
        CMBI_XFER: begin
          if (s_rdy) begin
            r_d.bus.wait_flag = 1'b0;
            r_d.st = CMBI_DONE;
          end else begin
            r_d.bus.wait_flag = 1'b1;
          end
        end
        CMBI_DONE: begin
          if (!r_q.cur.write)
            r_d.rdata = d2_q;
          r_d.req_done = 1'b1;
          r_d.bus = '0;
          r_d.bus.addr = r_q.bus.addr;
          r_d.st = CMBI_IDLE;
        end
        CMBI_HOLD: begin
          r_d.bus.bus_grant_ack = s_hold;
          if (!s_hold && !r_q.bus.bus_grant_ack)
            r_d.st = CMBI_IDLE;
        end
        CMBI_SER: begin
          // One strobe per bit; core sequences multi-bit loads
          r_d.sio.serial_strobe = 1'b1;
          r_d.ser_in   = sin2_q;
          r_d.ser_done = 1'b1;
          r_d.st = CMBI_IDLE;
        end
        default: r_d.st = CMBI_IDLE;
      endcase
    end
    // Set after the clears above so a load edge in the cycle of a clear is kept; an edge during reset is dropped at reset entry
    if (s_load && !r_q.load_prev)
      r_d.pend_nmi = 1'b1;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      r_q <= '0;
      r_q.st <= CMBI_RST;
      r_q.pend_rst <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign bus          = r_q.bus;
  assign sio          = r_q.sio;
  assign core_done    = r_q.req_done;
  assign core_rdata   = r_q.rdata;
  assign ser_done     = r_q.ser_done;
  assign ser_in_val   = r_q.ser_in;
  assign vec_take     = r_q.vec_pulse;
  assign vec_addr     = r_q.vec;
  assign status_clear = r_q.status_clr;
  assign irq_level    = r_q.irq_level;
  assign irq_pending  = r_q.irq_seen;
endmodule : cmbi_top

//--- bench/cmbi_properties.sv
// Protocol checker for the bus interface top ports.
// Assumes a bind from the bench top file.
`timescale 1ns/1ps
module cmbi_properties (
  input wire logic                clock,
  input wire logic                rstn,
  input wire cmbi_pkg::cmbi_bus_t bus,
  input wire logic                core_done,
  input wire logic                status_clear,
  input wire logic                vec_take,
  input wire logic [14:0]         vec_addr
);
  import cmbi_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ==========================================================
  // Strobe relations
  a_read_strobes: assert property (
    bus.data_in_strobe |-> bus.mem_cycle_enable && !bus.write_enable)
    else $error("read strobes wrong");
  a_read_drv_off: assert property (
    bus.data_in_strobe |-> !bus.data_oe) else $error("driver on in read");
  a_write_strobes: assert property (
    bus.write_enable |-> bus.mem_cycle_enable && !bus.data_in_strobe)
    else $error("write strobes wrong");
  a_write_stable: assert property (
    bus.write_enable && $past(bus.write_enable) |->
      $stable(bus.addr) && $stable(bus.data)) else $error("write moved");
  a_mem_addr: assert property (
    bus.mem_cycle_enable |-> bus.addr_oe) else $error("enable no address");
  a_wait_cycle: assert property (
    bus.wait_flag |-> bus.mem_cycle_enable) else $error("wait outside cycle");
  a_fetch_cycle: assert property (
    bus.instr_fetch_flag |-> bus.mem_cycle_enable) else $error("stray fetch");
  // ==========================================================
  // Hold, done pulse and entry
  a_grant_float: assert property (
    bus.bus_grant_ack |-> !bus.addr_oe && !bus.data_oe)
    else $error("bus driven in hold");
  a_grant_after: assert property (
    $rose(bus.bus_grant_ack) |-> !$past(bus.addr_oe) && !$past(bus.data_oe))
    else $error("grant before float");
  a_done_pulse: assert property (
    core_done |=> !core_done) else $error("done too long");
  a_status_vec: assert property (
    status_clear |-> vec_take && vec_addr == 15'h0000)
    else $error("status clear without reset entry");
endmodule : cmbi_properties

//--- bench/cmbi_mem_model.sv
// Memory partner: 16 words, ready after a stall count.
// Assumes the bus struct of the bus interface top.
`timescale 1ns/1ps
module cmbi_mem_model (
  input wire logic                clock,
  input wire logic                rstn,
  input wire cmbi_pkg::cmbi_bus_t bus,
  input wire logic [3:0]          stall,
  output logic [15:0]             data_i,
  output logic                    ready
);
  import cmbi_pkg::*;
  // Byte-wide halves, as the outside logic only handles bytes
  logic [7:0]  mem_hi [16];
  logic [7:0]  mem_lo [16];
  logic [15:0] last_q;
  logic [3:0]  cnt_q;
  // Low address bits only; upper lines ignored as a paired array
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 4'h0;
      last_q <= 16'h0000;
    end else begin
      cnt_q <= !bus.mem_cycle_enable ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
      if (bus.write_enable && bus.data_oe) begin
        mem_hi[bus.addr[3:0]] <= bus.data[15:8];
        mem_lo[bus.addr[3:0]] <= bus.data[7:0];
      end
      if (bus.data_in_strobe) last_q <= data_i;
    end
  end
  assign ready = bus.mem_cycle_enable && cnt_q >= stall;
  // Released bus shows the inverse so stale data never matches
  // Strobe steers both bytes onto the word bus together
  assign data_i = bus.data_in_strobe ?
    {mem_hi[bus.addr[3:0]], mem_lo[bus.addr[3:0]]} : ~last_q;
endmodule : cmbi_mem_model

//--- bench/tb_cmbi_top.sv
// Self-checking bench for the bus interface top.
// Assumes the memory partner and the checker beside it.
`timescale 1ns/1ps
`include "cmbi_map.svh"
module tb_cmbi_top;
  import cmbi_pkg::*;
  typedef struct packed {
    logic w; logic f; logic [14:0] a; logic [15:0] d; logic [3:0] s;
  } cmbi_row_t;
  logic clock = 0, rstn = 0, hold = 0, load = 0, reset_in = 0, irq_in = 0;
  logic core_done, ser_done, ser_in_val, vec_take, status_clear, irq_pending;
  logic ready, serial_in_bit = 0;
  logic [3:0] irq_lv = 4'h0, irq_level, stall = 4'h0;
  logic [14:0] vec_addr;
  logic [15:0] core_rdata, data_i, shadow [16];
  cmbi_req_t core_req = '0;
  cmbi_ser_req_t ser_req = '0;
  cmbi_bus_t bus;
  cmbi_ser_t sio;
  int n_fail = 0, check_count = 0, i, k;
  cmbi_row_t rows [6] = '{'{1,0,15'h0003,16'ha5c3,0}, '{0,1,15'h0003,0,0},
    '{1,0,15'h7ffc,16'hffff,8}, '{0,0,15'h7ffc,0,8},
    '{1,0,15'h0100,16'h0001,2}, '{0,1,15'h0100,0,2}};
  always #2 clock = ~clock;
  cmbi_top #(.PHASE_CYC(1)) u_cmbi_top (.clock, .rstn, .core_req,
    .core_done, .core_rdata, .ser_req, .ser_done, .ser_in_val, .vec_take,
    .vec_addr, .status_clear, .irq_level, .irq_pending, .bus, .sio, .data_i,
    .ready, .hold, .load, .reset_in, .irq_in, .irq_level_msb(irq_lv[3]),
    .irq_level_b1(irq_lv[2]), .irq_level_b2(irq_lv[1]),
    .irq_level_lsb(irq_lv[0]), .serial_in_bit);
  cmbi_mem_model u_cmbi_mem_model (.clock, .rstn, .bus, .stall, .data_i,
    .ready);
  // ==========================================================
  // Shared tasks
  task check(input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value t=%0t got %h exp %h", $time, seen, exp);
    end
  endtask : check
  task complete_run;
    $display("checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task wait_ok(input logic ok);
    if (!ok) begin
      n_fail++;
      complete_run;
    end
  endtask : wait_ok
  task automatic mem_op(input cmbi_row_t r);
    logic sw, sf, se;
    sw = 0; sf = 0; se = 0;
    @(negedge clock);
    stall = r.s;
    core_req = '{1'b1, r.w, r.f, r.a, r.d};
    for (i = 0; i < 400 && core_done !== 1'b1; i++) begin
      @(posedge clock); #1;
      sw |= bus.wait_flag;
      sf |= bus.instr_fetch_flag;
      se |= bus.write_enable;
    end
    wait_ok(i < 400);
    if (r.w) shadow[r.a[3:0]] = r.d;
    else check(core_rdata, shadow[r.a[3:0]]);
    check(sf, r.f);
    check(se, r.w);
    if (r.s == 4'h8) check(sw, 1'b1);
    @(negedge clock);
    core_req.valid = 0;
  endtask : mem_op
  task wait_vec;
    for (i = 0; i < 100 && vec_take !== 1'b1; i++) begin
      @(posedge clock); #1;
    end
    wait_ok(i < 100);
  endtask : wait_vec
  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    check(64'(bus), 64'h0);
    @(negedge clock) rstn = 1;
    wait_vec();
    check({vec_addr, status_clear}, {15'h0000, 1'b1});
    foreach (rows[j]) mem_op(rows[j]);
    @(negedge clock) load = 1;
    wait_vec();
    check(vec_addr, 15'h7ffe);
    @(negedge clock) load = 0;
    hold = 1;
    for (i = 0; i < 100 && bus.bus_grant_ack !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    wait_ok(i < 100);
    check({bus.addr_oe, bus.data_oe}, 2'b00);
    @(negedge clock) hold = 0;
    irq_in = 1;
    irq_lv = 4'hb;
    serial_in_bit = 1;
    for (i = 0; i < 100 && bus.bus_grant_ack !== 1'b0; i++) begin
      @(posedge clock);
      #1;
    end
    wait_ok(i < 100);
    mem_op(rows[1]);
    check({irq_pending, irq_level}, 5'h1b);
    for (k = 1; k <= 3; k++) begin
      logic sb, st;
      logic [14:0] sa;
      st = 0;
      @(negedge clock) ser_req = '{1'b1, k[3:0], 15'h0006 * k[14:0], k[0]};
      for (i = 0; i < 100 && ser_done !== 1'b1; i++) begin
        @(posedge clock); #1;
        if (sio.serial_strobe === 1'b1)
          {st, sb, sa} = {1'b1, sio.serial_out_bit, sio.addr};
      end
      wait_ok(i < 100);
      check({st, sb}, {1'b1, k[0]});
      check(sa, 15'h0006 * k[14:0]);
      @(negedge clock) ser_req.start = 0;
    end
    check(ser_in_val, 1'b1);
    // Reset pin in mid-run: buses cleared, then reset entry again
    @(negedge clock) reset_in = 1;
    repeat (4) @(negedge clock);
    check(64'(bus), 64'h0);
    reset_in = 0;
    wait_vec();
    check({vec_addr, status_clear}, {15'h0000, 1'b1});
    complete_run;
  end
endmodule : tb_cmbi_top
bind cmbi_top cmbi_properties u_cmbi_properties (.clock(clock),
  .rstn(rstn), .bus(bus), .core_done(core_done), .status_clear(status_clear),
  .vec_take(vec_take), .vec_addr(vec_addr));
